// ==== rtl/sacmc_defines.svh ====
// Contract
// - Access rights follow both the register's intrinsic function and the current CPU mode.
// - Blocked writes change nothing but the blocked status bit; blocked reads return a fixed value.
// - Some registers exist three times: user, system and super system copies.
// - Component groups use MMU-delivered rights; other registers have fixed rights.
// - User and contactless code cannot reach any of 16 groups until granted.
// - Two mode flags: super-system, system; both clear means user mode.
// - System-call vector sets system flag; configuration vector sets super-system flag.
// - System-call vector call outside user mode raises an exception.
// - On some variants a configuration vector call is an ordinary call.
// - Every exception entry sets the system flag.
// - Interrupt entry sets system flag unless interrupts are configured for user mode.
// - Return-from-interrupt restores the mode flags held before the event.
// - User-mode return needs user interrupts enabled and an active interrupt, else exception.
// - System-mode call to 0x800000 enters user mode without pushing a return address.
// - Software writes to the mode flags can only clear them.
// - System mode reaches all component registers and system management registers.
// - Boot, test, system see full group rights; contactless uses two locked registers.
`ifndef SACMC_DEFINES_SVH
`define SACMC_DEFINES_SVH

// Register offsets
`define SACMC_ADDR_MODE 8'h00
`define SACMC_ADDR_INT_CFG 8'h01
`define SACMC_ADDR_IRQ_STAT 8'h02
`define SACMC_ADDR_IRQ_MASK 8'h03
`define SACMC_ADDR_CL_GRANT_LO 8'h04
`define SACMC_ADDR_CL_GRANT_HI 8'h05
`define SACMC_ADDR_BANKED 8'h06

// Component register window
`define SACMC_HW_WIN_MASK 8'hc0
`define SACMC_HW_BASE 8'h40
`define SACMC_GRP_MSB 5
`define SACMC_GRP_LSB 2

// Mode flag reset: super system (boot) after reset
`define SACMC_FLAGS_RESET 2'h2

// Interrupt status bits
`define SACMC_IRQ_W 3
`define SACMC_IRQ_BLOCKED 0
`define SACMC_IRQ_BAD_SYSTEM_CALL_VECTOR 1
`define SACMC_IRQ_BAD_RETURN_FROM_INTERRUPT 2

// Bank indices
`define SACMC_BANK_USER 2'h0
`define SACMC_BANK_SYS 2'h1
`define SACMC_BANK_SUPER 2'h2

// Fixed answer of a blocked read
`define SACMC_BLOCKED_DATA 8'h00

// Entry address of user mode
`define SACMC_USER_ENTRY 24'h800000

`endif

// ==== rtl/sacmc_pkg.sv ====
package sacmc_pkg;

  typedef struct packed {
    logic ssm;
    logic sm;
  } sacmc_flags_t;

  typedef struct packed {
    logic is_int;
    sacmc_flags_t flags;
  } sacmc_frame_t;

  typedef struct packed {
    logic rd_ok;
    logic wr_ok;
    logic is_hw;
    logic [3:0] group;
  } sacmc_acc_t;

endpackage : sacmc_pkg

// ==== rtl/sacmc_top.sv ====
`timescale 1ns/1ps
`include "sacmc_defines.svh"

module sacmc_top
  import sacmc_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter logic [15:0] HW_RO_MASK = 16'h0001,
  parameter logic [15:0] HW_WO_MASK = 16'h0006,
  parameter logic CONFIGURATION_CALL_VECTOR_ENABLE = 1'b1,
  parameter logic [23:0] SYSTEM_CALL_VECTOR_BASE = 24'h000100,
  parameter logic [23:0] CONFIGURATION_CALL_VECTOR_BASE = 24'h000200,
  parameter logic [23:0] VEC_MASK = 24'hffff80
)
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // Component register fabric
  output logic HW_WR_OUT,
  output logic HW_RD_OUT,
  output logic [7:0] HW_ADDR_OUT,
  output logic [7:0] HW_WDATA_OUT,
  input wire logic [7:0] HW_RDATA_IN,
  // Rights from the MMU and super system kind
  input wire logic [15:0] MMU_RD_GRANT_IN,
  input wire logic [15:0] MMU_WR_GRANT_IN,
  input wire logic CONTACTLESS_IN,
  // CPU events
  input wire logic CALL_IN,
  input wire logic [23:0] CALL_TARGET_IN,
  input wire logic EXC_IN,
  input wire logic INT_IN,
  input wire logic RETURN_FROM_INTERRUPT_IN,
  // Mode and event outputs
  output logic [1:0] MODE_FLAGS_OUT,
  output logic EXC_OUT,
  output logic SKIP_PUSH_OUT,
  output logic IRQ_OUT
);

  localparam int PTR_W = $clog2(STACK_DEPTH);
  localparam logic [PTR_W:0] SP_FULL = STACK_DEPTH[PTR_W:0];

  typedef struct packed {
    sacmc_flags_t flags;
    logic int_user;
    logic [`SACMC_IRQ_W-1:0] irq_stat;
    logic [`SACMC_IRQ_W-1:0] irq_mask;
    logic [15:0] cl_grant;
    logic [2:0][7:0] bank;
    sacmc_frame_t [STACK_DEPTH-1:0] stack;
    logic [PTR_W:0] sp;
    logic [PTR_W:0] int_cnt;
    logic [7:0] rdata;
    logic exc;
    logic skip_push;
  } sacmc_state_t;

  sacmc_state_t state_reg;
  sacmc_state_t state_next;
  sacmc_acc_t acc;

  // Access decision for one address in the current mode
  function automatic sacmc_acc_t sacmc_decode(
    input logic [7:0] addr,
    input sacmc_flags_t f,
    input logic cl,
    input logic [15:0] urd,
    input logic [15:0] uwr,
    input logic [15:0] clg
  );
    sacmc_acc_t a;
    logic priv;
    logic [15:0] grd;
    logic [15:0] gwr;
    a = '0;
    priv = f.ssm | f.sm;
    if (f.ssm && cl)
    begin
      grd = clg;
      gwr = clg;
    end
    else if (priv)
    begin
      grd = '1;
      gwr = '1;
    end
    else
    begin
      grd = urd;
      gwr = uwr;
    end
    if ((addr & `SACMC_HW_WIN_MASK) == `SACMC_HW_BASE)
    begin
      a.is_hw = 1'b1;
      a.group = addr[`SACMC_GRP_MSB:`SACMC_GRP_LSB];
      a.rd_ok = grd[a.group] & ~HW_WO_MASK[a.group];
      a.wr_ok = gwr[a.group] & ~HW_RO_MASK[a.group];
    end
    else if (addr == `SACMC_ADDR_MODE || addr == `SACMC_ADDR_BANKED)
    begin
      a.rd_ok = 1'b1;
      a.wr_ok = 1'b1;
    end
    else if (addr == `SACMC_ADDR_INT_CFG || addr == `SACMC_ADDR_IRQ_STAT || addr == `SACMC_ADDR_IRQ_MASK)
    begin
      a.rd_ok = 1'b1;
      a.wr_ok = priv;
    end
    else if (addr == `SACMC_ADDR_CL_GRANT_LO || addr == `SACMC_ADDR_CL_GRANT_HI)
    begin
      a.rd_ok = 1'b1;
      a.wr_ok = priv & ~(f.ssm & cl);
    end
    else
    begin
      a.rd_ok = 1'b1;
      a.wr_ok = 1'b1;
    end
    return a;
  endfunction : sacmc_decode

  // Copy index of a banked register
  function automatic logic [1:0] sacmc_bank(input sacmc_flags_t f);
    if (f.ssm)
    begin
      return `SACMC_BANK_SUPER;
    end
    else if (f.sm)
    begin
      return `SACMC_BANK_SYS;
    end
    return `SACMC_BANK_USER;
  endfunction : sacmc_bank

  assign acc = sacmc_decode(ADDR_IN, state_reg.flags, CONTACTLESS_IN, MMU_RD_GRANT_IN, MMU_WR_GRANT_IN,
                            state_reg.cl_grant);

  // Forward allowed component accesses only
  assign HW_WR_OUT = WR_IN & acc.is_hw & acc.wr_ok;
  assign HW_RD_OUT = RD_IN & acc.is_hw & acc.rd_ok;
  assign HW_ADDR_OUT = ADDR_IN;
  assign HW_WDATA_OUT = WDATA_IN;

  always_comb
  begin
    logic [`SACMC_IRQ_W-1:0] ev;
    logic [1:0] bidx;
    logic user;
    logic do_push;
    logic do_exc;
    logic system_call_vector_hit;
    logic configuration_call_vector_hit;
    sacmc_frame_t frame;
    sacmc_flags_t nflags;
    logic [PTR_W-1:0] top_idx;
    state_next = state_reg;
    ev = '0;
    bidx = sacmc_bank(state_reg.flags);
    user = ~(state_reg.flags.ssm | state_reg.flags.sm);
    do_push = 1'b0;
    do_exc = 1'b0;
    system_call_vector_hit = (CALL_TARGET_IN & VEC_MASK) == SYSTEM_CALL_VECTOR_BASE;
    configuration_call_vector_hit = (CALL_TARGET_IN & VEC_MASK) == CONFIGURATION_CALL_VECTOR_BASE;
    frame = '0;
    nflags = state_reg.flags;
    top_idx = PTR_W'(state_reg.sp - 1'b1);
    state_next.exc = 1'b0;
    state_next.skip_push = 1'b0;
    state_next.rdata = `SACMC_BLOCKED_DATA;

    // Register writes
    if (WR_IN)
    begin
      if (!acc.wr_ok)
      begin
        ev[`SACMC_IRQ_BLOCKED] = 1'b1;
      end
      else if (ADDR_IN == `SACMC_ADDR_MODE)
      begin
        nflags = state_reg.flags & sacmc_flags_t'(WDATA_IN[1:0]);
      end
      else if (ADDR_IN == `SACMC_ADDR_INT_CFG)
      begin
        state_next.int_user = WDATA_IN[0];
      end
      else if (ADDR_IN == `SACMC_ADDR_IRQ_STAT)
      begin
        state_next.irq_stat = state_reg.irq_stat & ~WDATA_IN[`SACMC_IRQ_W-1:0];
      end
      else if (ADDR_IN == `SACMC_ADDR_IRQ_MASK)
      begin
        state_next.irq_mask = WDATA_IN[`SACMC_IRQ_W-1:0];
      end
      else if (ADDR_IN == `SACMC_ADDR_CL_GRANT_LO)
      begin
        state_next.cl_grant[7:0] = WDATA_IN;
      end
      else if (ADDR_IN == `SACMC_ADDR_CL_GRANT_HI)
      begin
        state_next.cl_grant[15:8] = WDATA_IN;
      end
      else if (ADDR_IN == `SACMC_ADDR_BANKED)
      begin
        state_next.bank[bidx] = WDATA_IN;
      end
    end

    // Register reads, answered in the next cycle either way
    if (RD_IN)
    begin
      if (!acc.rd_ok)
      begin
        ev[`SACMC_IRQ_BLOCKED] = 1'b1;
      end
      else if (acc.is_hw)
      begin
        state_next.rdata = HW_RDATA_IN;
      end
      else if (ADDR_IN == `SACMC_ADDR_MODE)
      begin
        state_next.rdata = {6'h00, state_reg.flags};
      end
      else if (ADDR_IN == `SACMC_ADDR_INT_CFG)
      begin
        state_next.rdata = {7'h00, state_reg.int_user};
      end
      else if (ADDR_IN == `SACMC_ADDR_IRQ_STAT)
      begin
        state_next.rdata = {5'h00, state_reg.irq_stat};
      end
      else if (ADDR_IN == `SACMC_ADDR_IRQ_MASK)
      begin
        state_next.rdata = {5'h00, state_reg.irq_mask};
      end
      else if (ADDR_IN == `SACMC_ADDR_CL_GRANT_LO)
      begin
        state_next.rdata = state_reg.cl_grant[7:0];
      end
      else if (ADDR_IN == `SACMC_ADDR_CL_GRANT_HI)
      begin
        state_next.rdata = state_reg.cl_grant[15:8];
      end
      else if (ADDR_IN == `SACMC_ADDR_BANKED)
      begin
        state_next.rdata = state_reg.bank[bidx];
      end
    end

    // Mode events; exceptions, interrupts, user entry and stacked returns override a same-cycle flag write, vector calls add to it
    frame.flags = state_reg.flags;
    if (EXC_IN)
    begin
      do_exc = 1'b1;
    end
    else if (RETURN_FROM_INTERRUPT_IN)
    begin
      if (user && !(state_reg.int_user && state_reg.int_cnt != '0))
      begin
        do_exc = 1'b1;
        ev[`SACMC_IRQ_BAD_RETURN_FROM_INTERRUPT] = 1'b1;
      end
      else if (state_reg.sp != '0)
      begin
        nflags = state_reg.stack[top_idx].flags;
        state_next.sp = state_reg.sp - 1'b1;
        if (state_reg.stack[top_idx].is_int)
        begin
          state_next.int_cnt = state_reg.int_cnt - 1'b1;
        end
      end
    end
    else if (INT_IN)
    begin
      do_push = 1'b1;
      frame.is_int = 1'b1;
      nflags = state_reg.flags;
      if (!state_reg.int_user)
      begin
        nflags.sm = 1'b1;
      end
    end
    else if (CALL_IN)
    begin
      if (system_call_vector_hit)
      begin
        if (user)
        begin
          do_push = 1'b1;
          nflags.sm = 1'b1;
        end
        else
        begin
          do_exc = 1'b1;
          ev[`SACMC_IRQ_BAD_SYSTEM_CALL_VECTOR] = 1'b1;
        end
      end
      else if (configuration_call_vector_hit && CONFIGURATION_CALL_VECTOR_ENABLE)
      begin
        do_push = 1'b1;
        nflags.ssm = 1'b1;
      end
      else if (CALL_TARGET_IN == `SACMC_USER_ENTRY && state_reg.flags.sm && !state_reg.flags.ssm)
      begin
        nflags = '0;
        state_next.skip_push = 1'b1;
      end
    end

    // Exception entry always sets the system flag; a super system flag stays set
    if (do_exc)
    begin
      do_push = 1'b1;
      frame.is_int = 1'b0;
      frame.flags = state_reg.flags;
      nflags = state_reg.flags;
      nflags.sm = 1'b1;
      state_next.exc = 1'b1;
    end

    // Save the mode for the matching return
    if (do_push)
    begin
      if (state_reg.sp != SP_FULL)
      begin
        state_next.stack[state_reg.sp[PTR_W-1:0]] = frame;
        state_next.sp = state_reg.sp + 1'b1;
        if (frame.is_int)
        begin
          state_next.int_cnt = state_reg.int_cnt + 1'b1;
        end
      end
      else
      begin
        state_next.exc = 1'b1;
      end
    end

    state_next.flags = nflags;
    state_next.irq_stat = state_next.irq_stat | ev;
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      state_reg <= '0;
      state_reg.flags <= sacmc_flags_t'(`SACMC_FLAGS_RESET);
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign RDATA_OUT = state_reg.rdata;
  assign MODE_FLAGS_OUT = state_reg.flags;
  assign EXC_OUT = state_reg.exc;
  assign SKIP_PUSH_OUT = state_reg.skip_push;
  assign IRQ_OUT = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule : sacmc_top

// ==== verif/sacmc_props.sv ====
`timescale 1ns/1ps
module sacmc_props
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  // Fabric
  input wire logic HW_WR_OUT,
  input wire logic HW_RD_OUT,
  input wire logic [7:0] HW_RDATA_IN,
  input wire logic [15:0] MMU_RD_GRANT_IN,
  // Events
  input wire logic CALL_IN,
  input wire logic [23:0] CALL_TARGET_IN,
  input wire logic EXC_IN,
  input wire logic INT_IN,
  input wire logic RETURN_FROM_INTERRUPT_IN,
  input wire logic [1:0] MODE_FLAGS_OUT,
  input wire logic EXC_OUT,
  input wire logic SKIP_PUSH_OUT
);
  wire logic hw = ADDR_IN[7:6] == 2'h1;
  wire logic ev = CALL_IN | EXC_IN | INT_IN | RETURN_FROM_INTERRUPT_IN;
  wire logic call = CALL_IN & !EXC_IN & !INT_IN & !RETURN_FROM_INTERRUPT_IN;
  wire logic system_call_vector = (CALL_TARGET_IN & 24'hffff80) == 24'h000100;
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  blk_read_zero_a: assert property (RD_IN && hw && !HW_RD_OUT |=> RDATA_OUT == 8'h00)
    else $error("blocked read data");
  idle_read_zero_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
    else $error("idle read data");
  hw_read_path_a: assert property (HW_RD_OUT |=> RDATA_OUT == $past(HW_RDATA_IN))
    else $error("read path");
  user_grant_a: assert property (MODE_FLAGS_OUT == 2'h0 && RD_IN && hw && !MMU_RD_GRANT_IN[ADDR_IN[5:2]]
    |-> !HW_RD_OUT)
    else $error("user read leak");
  sys_full_a: assert property (MODE_FLAGS_OUT == 2'h1 && WR_IN && hw && ADDR_IN[5:2] != 4'h0 |-> HW_WR_OUT)
    else $error("system write blocked");
  system_call_vector_enter_a: assert property (MODE_FLAGS_OUT == 2'h0 && call && system_call_vector |=> MODE_FLAGS_OUT == 2'h1)
    else $error("vector entry");
  system_call_vector_refuse_a: assert property (MODE_FLAGS_OUT != 2'h0 && call && system_call_vector |=> EXC_OUT)
    else $error("vector not refused");
  exc_sys_a: assert property (EXC_IN |=> EXC_OUT && MODE_FLAGS_OUT[0])
    else $error("exception entry");
  flags_clear_a: assert property (!ev |=> (MODE_FLAGS_OUT & ~$past(MODE_FLAGS_OUT)) == 2'h0)
    else $error("flag set");
  user_entry_a: assert property (MODE_FLAGS_OUT == 2'h1 && call && CALL_TARGET_IN == 24'h800000
    |=> SKIP_PUSH_OUT && MODE_FLAGS_OUT == 2'h0)
    else $error("user entry");
endmodule : sacmc_props

bind sacmc_top sacmc_props u_props (.*);

// ==== verif/sacmc_fabric_model.sv ====
`timescale 1ns/1ps
module sacmc_fabric_model
(
  // Fabric side
  input wire logic clk_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem_reg [64];
  initial
  begin
    for (int i = 0; i < 64; i++) mem_reg[i] = 8'(i) ^ 8'h5a;
  end
  always @(posedge clk_in)
  begin
    if (wr_in) mem_reg[addr_in[5:0]] <= wdata_in;
  end
  // Unselected bus shows inverted data
  assign rdata_out = rd_in ? mem_reg[addr_in[5:0]] : ~mem_reg[addr_in[5:0]];
endmodule : sacmc_fabric_model

// ==== verif/sacmc_top_tb.sv ====
`timescale 1ns/1ps
module sacmc_top_tb;
  logic CLK_IN, NRST_IN, WR_IN, RD_IN, HW_WR_OUT, HW_RD_OUT, CONTACTLESS_IN;
  logic CALL_IN, EXC_IN, INT_IN, RETURN_FROM_INTERRUPT_IN, EXC_OUT, SKIP_PUSH_OUT, IRQ_OUT;
  logic [7:0] ADDR_IN, WDATA_IN, RDATA_OUT, HW_ADDR_OUT, HW_WDATA_OUT, HW_RDATA_IN;
  logic [15:0] MMU_RD_GRANT_IN, MMU_WR_GRANT_IN;
  logic [23:0] CALL_TARGET_IN;
  logic [1:0] MODE_FLAGS_OUT;
  logic [7:0] mm [16];
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  sacmc_top uut (.*);
  sacmc_fabric_model u_fab (.clk_in(CLK_IN), .wr_in(HW_WR_OUT), .rd_in(HW_RD_OUT), .addr_in(HW_ADDR_OUT),
    .wdata_in(HW_WDATA_OUT), .rdata_out(HW_RDATA_IN));
  always #5 CLK_IN = ~CLK_IN;
  task end_of_test;
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge CLK_IN)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_of_test;
    end
  end
  task chk(input logic [7:0] s, e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, d);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge CLK_IN);
    WR_IN <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, e);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge CLK_IN);
    RD_IN <= 1'b0;
    #1;
    chk(RDATA_OUT, e);
  endtask : rd
  task ev(input logic [3:0] k, input logic [23:0] t, input logic [3:0] e);
    @(posedge CLK_IN);
    {CALL_IN, EXC_IN, INT_IN, RETURN_FROM_INTERRUPT_IN} <= k;
    CALL_TARGET_IN <= t;
    @(posedge CLK_IN);
    {CALL_IN, EXC_IN, INT_IN, RETURN_FROM_INTERRUPT_IN} <= 4'h0;
    #1;
    chk({4'h0, MODE_FLAGS_OUT, EXC_OUT, SKIP_PUSH_OUT}, {4'h0, e});
  endtask : ev
  function automatic logic [7:0] exp_rd(input int g, input logic rok);
    return (rok && g != 1 && g != 2) ? mm[g] : 8'h00;
  endfunction : exp_rd
  task acc(input int g, input logic wok, rok);
    logic [7:0] d;
    d = 8'($urandom);
    wr(8'h40 + 8'(4 * g), d);
    if (wok && g != 0) mm[g] = d;
    rd(8'h40 + 8'(4 * g), exp_rd(g, rok));
  endtask : acc
  initial
  begin
    {CLK_IN, NRST_IN, WR_IN, RD_IN, CONTACTLESS_IN, CALL_IN, EXC_IN, INT_IN, RETURN_FROM_INTERRUPT_IN} = 9'h0;
    {ADDR_IN, WDATA_IN, MMU_RD_GRANT_IN, MMU_WR_GRANT_IN, CALL_TARGET_IN} = 72'h0;
    for (int g = 0; g < 16; g++) mm[g] = 8'(4 * g) ^ 8'h5a;
    void'($urandom(32'ha752));
    repeat (6) @(posedge CLK_IN);
    NRST_IN <= 1'b1;
    #1;
    chk({6'h0, MODE_FLAGS_OUT}, 8'h02);
    for (int g = 0; g < 16; g++) acc(g, 1'b1, 1'b1);
    wr(8'h06, 8'ha1);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    wr(8'h06, 8'hb2);
    rd(8'h06, 8'hb2);
    @(posedge CLK_IN);
    MMU_RD_GRANT_IN <= 16'($urandom) & 16'hfff7;
    MMU_WR_GRANT_IN <= 16'($urandom);
    #1;
    for (int g = 0; g < 16; g++) acc(g, MMU_WR_GRANT_IN[g], MMU_RD_GRANT_IN[g]);
    ev(4'h8, 24'h000100, 4'h4);
    rd(8'h06, 8'h00);
    rd(8'h02, 8'h01);
    wr(8'h03, 8'h01);
    #1;
    chk({7'h0, IRQ_OUT}, 8'h01);
    wr(8'h02, 8'h01);
    #1;
    chk({7'h0, IRQ_OUT}, 8'h00);
    acc(5, 1'b1, 1'b1);
    ev(4'h8, 24'h000100, 4'h6);
    ev(4'h1, 24'h0, 4'h4);
    ev(4'h1, 24'h0, 4'h0);
    ev(4'h1, 24'h0, 4'h6);
    rd(8'h02, 8'h06);
    ev(4'h1, 24'h0, 4'h0);
    ev(4'h8, 24'h000100, 4'h4);
    wr(8'h01, 8'h01);
    ev(4'h8, 24'h800000, 4'h1);
    ev(4'h2, 24'h0, 4'h0);
    ev(4'h1, 24'h0, 4'h0);
    ev(4'h4, 24'h0, 4'h6);
    wr(8'h01, 8'h00);
    ev(4'h8, 24'h800000, 4'h1);
    ev(4'h2, 24'h0, 4'h4);
    wr(8'h04, 8'h08);
    wr(8'h05, 8'h00);
    ev(4'h8, 24'h000200, 4'hc);
    @(posedge CLK_IN);
    CONTACTLESS_IN <= 1'b1;
    wr(8'h04, 8'hff);
    acc(3, 1'b1, 1'b1);
    acc(4, 1'b0, 1'b0);
    rd(8'h06, 8'ha1);
    ev(4'h1, 24'h0, 4'h4);
    @(posedge CLK_IN);
    NRST_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    NRST_IN <= 1'b1;
    #1;
    chk({6'h0, MODE_FLAGS_OUT}, 8'h02);
    ev(4'h1, 24'h0, 4'h8);
    end_of_test;
  end
endmodule : sacmc_top_tb
